/* verilog/lfm_top.sv */
// Purpose: normal-state fault supervision
// Assumes: analog comparators and pins enter through two-flop sync
// Notes: nrst_i is power-on reset, also used after regulator shutdown
`timescale 1ns/1ps
module lfm_top
    import lfm_pkg::*;
#(
    parameter int PULSE_CYCLES = PULSE_CYC,
    parameter int WD_UNIT_CYCLES = WD_UNIT_CYC,
    parameter int DEG_OPEN_CYCLES = OPEN_DEG_CYC,
    parameter int DEG_SHORT_CYCLES = SHORT_DEG_CYC,
    parameter int ODPW_CYCLES = ODPW_UNIT_CYC
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic nrst_i,
    // Supply ADC
    input wire logic adc_done_i,
    input wire logic adc_idle_i,
    input wire logic [7:0] adc_code_i,
    input wire logic [7:0] low_supply_threshold_i,
    // Analog comparators (async)
    input wire logic ref_open_i,
    input wire logic ref_short_i,
    input wire logic thermal_warn_i,
    input wire logic overtemp_i,
    input wire logic [NCH-1:0] pwm_on_i,
    input wire logic [NCH-1:0] open_cmp_i,
    input wire logic [NCH-1:0] short_cmp_i,
    // Configuration
    input wire logic [3:0] diag_pulse_width_i,
    input wire logic [3:0] watchdog_period_i,
    input wire logic [3:0] stored_watchdog_period_i,
    input wire logic failsafe_select_i,
    input wire logic mask_open_i,
    input wire logic mask_short_i,
    input wire logic clear_faults_i,
    // Frame receiver
    input wire logic frame_ok_i,
    input wire logic frame_broadcast_i,
    input wire logic frame_addr_match_i,
    // Status
    output logic [7:0] supply_result_o,
    output logic [7:0] supply_threshold_o,
    output lfm_flags_s flags_o,
    output logic [NCH-1:0] channel_open_flag_o,
    output logic [NCH-1:0] channel_short_flag_o,
    output logic clear_faults_o,
    output logic outputs_enable_o,
    output logic diag_enable_o,
    output lfm_state_e state_o,
    // Fault pin, open drain
    output logic fault_n_o,
    output logic fault_oe_o
);
    localparam int NSYNC = 4 + 3 * NCH;
    localparam int CW = 24;

    // =====================================
    // Synchronisers
    logic [NSYNC-1:0] s1_q, s2_q;
    logic ref_f, tw_f, ot_f, rsh_f;
    logic [NCH-1:0] pwm_f, open_f, short_f;

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            s1_q <= '0;
            s2_q <= '0;
        end else begin
            s1_q <= {ref_open_i, ref_short_i, thermal_warn_i, overtemp_i,
                pwm_on_i, open_cmp_i, short_cmp_i};
            s2_q <= s1_q;
        end
    end
    assign {ref_f, rsh_f, tw_f, ot_f, pwm_f, open_f, short_f} = s2_q;

    // =====================================
    // Threshold mapping
    // Code 0 sits at 5 V, code 255 at 20 V on the 80 mV/LSB supply scale
    function automatic logic [7:0] map_thr(input logic [7:0] c);
        logic [15:0] p;
        p = 16'(c) * 16'(THR_SPAN);
        return 8'(THR_MIN + p[15:8]);
    endfunction

    // =====================================
    // Supply result and low-supply detect
    logic [7:0] supply_q, supply_d;
    logic [7:0] thr_q, thr_d;
    logic low_q, low_d;

    always_comb begin
        supply_d = supply_q;
        thr_d = map_thr(low_supply_threshold_i);
        low_d = low_q;
        if (adc_done_i && adc_idle_i) begin
            supply_d = adc_code_i;
            low_d = adc_code_i < thr_q;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            supply_q <= 8'h00;
            thr_q <= THR_MIN;
            low_q <= 1'b0;
        end else begin
            supply_q <= supply_d;
            thr_q <= thr_d;
            low_q <= low_d;
        end
    end

    // =====================================
    // Channel diagnostics
    logic [CW-1:0] win_open, win_short;
    logic [NCH-1:0] ev_open, ev_short;

    assign win_open = CW'(ODPW_CYCLES * (int'(diag_pulse_width_i) + 1) + DEG_OPEN_CYCLES);
    assign win_short = CW'(ODPW_CYCLES * (int'(diag_pulse_width_i) + 1) + DEG_SHORT_CYCLES);

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            lfm_chan_diag #(.CW(CW)) u_open (
                .mclk_i(mclk_i),
                .nrst_i(nrst_i),
                .pwm_on_i(pwm_f[g]),
                .cmp_i(open_f[g]),
                .enable_i(!low_q),
                .window_i(win_open),
                .event_o(ev_open[g])
            );
            lfm_chan_diag #(.CW(CW)) u_short (
                .mclk_i(mclk_i),
                .nrst_i(nrst_i),
                .pwm_on_i(pwm_f[g]),
                .cmp_i(short_f[g]),
                .enable_i(1'b1),
                .window_i(win_short),
                .event_o(ev_short[g])
            );
        end
    endgenerate

    // =====================================
    // Flags
    lfm_flags_s flg_q, flg_d;
    logic [NCH-1:0] opn_q, opn_d, sht_q, sht_d;
    logic low_prev_q, tw_prev_q;
    logic ev_low, ev_tw, rep_open, rep_short, clr_q, clr_d;

    assign ev_low = low_q && !low_prev_q;
    assign ev_tw = tw_f && !tw_prev_q;
    assign rep_open = |ev_open && !mask_open_i;
    assign rep_short = |ev_short && !mask_short_i;

    always_comb begin
        flg_d = flg_q;
        opn_d = opn_q;
        sht_d = sht_q;
        clr_d = clear_faults_i;
        if (clr_q) begin
            flg_d = '0;
            opn_d = '0;
            sht_d = '0;
        end
        // Set wins over clear so no event is lost
        // low-supply flag
        if (ev_low) begin
            flg_d.low_supply = 1'b1;
        end
        if (ref_f || rsh_f) begin
            flg_d.reference = 1'b1;
            flg_d.global_fault = 1'b1;
        end
        if (ev_tw) begin
            flg_d.thermal_warning = 1'b1;
        end
        if (ot_f) begin
            flg_d.overtemp = 1'b1;
            flg_d.global_fault = 1'b1;
        end
        if (rep_open) begin
            opn_d = opn_d | ev_open;
            flg_d.output_fault = 1'b1;
            flg_d.global_fault = 1'b1;
        end
        if (rep_short) begin
            sht_d = sht_d | ev_short;
            flg_d.output_fault = 1'b1;
            flg_d.global_fault = 1'b1;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            flg_q <= '0;
            opn_q <= '0;
            sht_q <= '0;
            low_prev_q <= 1'b0;
            tw_prev_q <= 1'b0;
            clr_q <= 1'b0;
        end else begin
            flg_q <= flg_d;
            opn_q <= opn_d;
            sht_q <= sht_d;
            low_prev_q <= low_q;
            tw_prev_q <= tw_f;
            clr_q <= clr_d;
        end
    end

    // =====================================
    // Fault pin
    logic [CW-1:0] pcnt_q, pcnt_d;
    logic fn_q, fn_d, oen_q, oen_d, hold;
    logic pulse_ev;

    assign pulse_ev = ev_low || ev_tw || rep_open || rep_short;
    assign hold = ref_f || rsh_f || ot_f;

    always_comb begin
        pcnt_d = pcnt_q;
        if (pulse_ev) begin
            pcnt_d = CW'(PULSE_CYCLES);
        end else if (pcnt_q != '0) begin
            pcnt_d = pcnt_q - 1'b1;
        end
        oen_d = hold || (pcnt_d != '0);
        fn_d = !oen_d;
    end

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            pcnt_q <= '0;
            fn_q <= 1'b1;
            oen_q <= 1'b0;
        end else begin
            pcnt_q <= pcnt_d;
            fn_q <= fn_d;
            oen_q <= oen_d;
        end
    end

    // =====================================
    // Outputs, diag enable, watchdog
    logic outen_q, outen_d, diag_q, diag_d;
    logic [CW+3:0] wd_q, wd_d;
    lfm_state_e st_q, st_d;
    logic wd_kick;

    assign wd_kick = frame_ok_i && !frame_broadcast_i && frame_addr_match_i;

    always_comb begin
        outen_d = !ot_f;
        diag_d = !low_q;
        wd_d = wd_q;
        st_d = st_q;
        case (st_q)
            ST_NORMAL: begin
                if (wd_kick || watchdog_period_i == WD_OFF) begin
                    wd_d = '0;
                end else begin
                    wd_d = wd_q + 1'b1;
                end
                if (stored_watchdog_period_i == WD_DIRECT ||
                    (watchdog_period_i != WD_OFF &&
                    wd_q >= (CW+4)'(WD_UNIT_CYCLES) * (CW+4)'(watchdog_period_i))) begin
                    st_d = failsafe_select_i ? ST_FAILSAFE1 : ST_FAILSAFE0;
                end
            end
            ST_FAILSAFE0, ST_FAILSAFE1: begin
                wd_d = '0;
            end
            default: begin
                st_d = ST_NORMAL;
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            outen_q <= 1'b1;
            diag_q <= 1'b1;
            wd_q <= '0;
            st_q <= ST_NORMAL;
        end else begin
            outen_q <= outen_d;
            diag_q <= diag_d;
            wd_q <= wd_d;
            st_q <= st_d;
        end
    end

    assign supply_result_o = supply_q;
    assign supply_threshold_o = thr_q;
    assign flags_o = flg_q;
    assign channel_open_flag_o = opn_q;
    assign channel_short_flag_o = sht_q;
    assign clear_faults_o = clr_q;
    assign outputs_enable_o = outen_q;
    assign diag_enable_o = diag_q;
    assign state_o = st_q;
    assign fault_n_o = fn_q;
    assign fault_oe_o = oen_q;

    // =====================================
    // Checks
    property p_low_pulse;
        @(posedge mclk_i) disable iff (!nrst_i) ev_low |=> fault_oe_o && flg_q.low_supply;
    endproperty
    a_low_pulse: assert property (p_low_pulse) else $error("low supply not reported");
    property p_clr_self;
        @(posedge mclk_i) disable iff (!nrst_i) clr_q && !clear_faults_i |=> !clr_q;
    endproperty
    a_clr_self: assert property (p_clr_self) else $error("clear bit stuck");
    property p_hold;
        @(posedge mclk_i) disable iff (!nrst_i) hold |=> fault_oe_o && !fault_n_o;
    endproperty
    a_hold: assert property (p_hold) else $error("held pulldown released");
    property p_ot_off;
        @(posedge mclk_i) disable iff (!nrst_i) ot_f |=> !outputs_enable_o && flg_q.overtemp;
    endproperty
    a_ot_off: assert property (p_ot_off) else $error("outputs not off when hot");
    property p_ot_sticky;
        @(posedge mclk_i) disable iff (!nrst_i) flg_q.overtemp && !clr_q |=> flg_q.overtemp;
    endproperty
    a_ot_sticky: assert property (p_ot_sticky) else $error("overtemp flag lost");
    property p_wd_kick;
        @(posedge mclk_i) disable iff (!nrst_i)
            st_q == ST_NORMAL && wd_kick |=> wd_q == '0;
    endproperty
    a_wd_kick: assert property (p_wd_kick) else $error("watchdog not restarted");
    property p_wd_off;
        @(posedge mclk_i) disable iff (!nrst_i)
            st_q == ST_NORMAL && watchdog_period_i == WD_OFF &&
            stored_watchdog_period_i != WD_DIRECT |=> st_q == ST_NORMAL;
    endproperty
    a_wd_off: assert property (p_wd_off) else $error("disabled watchdog fired");
    property p_pulse_len;
        @(posedge mclk_i) disable iff (!nrst_i) pulse_ev |=> fault_oe_o [*8];
    endproperty
    a_pulse_len: assert property (p_pulse_len) else $error("fault pulse too short");
    property p_low_open;
        @(posedge mclk_i) disable iff (!nrst_i) low_q && $past(low_q) |-> !(|ev_open);
    endproperty
    a_low_open: assert property (p_low_open) else $error("open reported at low supply");
endmodule

/* verilog/lfm_pkg.sv */
// Purpose: constants and types for the LED driver fault monitor
// Assumes: 200 MHz mclk_i
// Notes: none
//
// Operation
// - Supply code below threshold: 50 us fault pulse, set low-supply flag.
// - Clear-faults write clears flags; the bit self-returns to zero.
// - Idle ADC converts supply to 8-bit code each cycle, updates result.
// - Open diagnosis enabled only above supply threshold; single-LED short diagnosis always enabled.
// - Threshold code maps onto a 5 V to 20 V supply range.
// - Reference open or short: hold fault low, set reference and global flags.
// - Reference fault takes no automatic output action.
// - Thermal warning: 50 us pulse, sticky warning flag until clear.
// - Overtemperature: outputs off, fault held, flags set; recover on cooling.
// - Overtemperature flag stays after recovery until clear-faults write.
// - Regulator shutdown recovers through power-on reset to defaults.
// - Watchdog restarts only on good addressed non-broadcast frames.
// - Watchdog overflow enters fail-safe state chosen by fail-safe select.
// - Period zero disables watchdog; stored 0xF enters fail-safe directly.
// - Open monitor only in on-time longer than pulse width plus deglitch.
// - Open held past pulse plus deglitch: pulse, channel, output, global flags.
// - Below supply threshold no open fault detected or reported.
// - Short monitor only in on-time longer than pulse width plus deglitch.
// - Short held past pulse plus deglitch: pulse, channel, output, global flags.
// - Short faults latch with no output action until cleared.
// - Masking suppresses reporting only; detection keeps running.
package lfm_pkg;
    localparam int CLK_MHZ = 200;
    localparam int PULSE_US = 50;
    localparam int PULSE_CYC = PULSE_US * CLK_MHZ;
    localparam int NCH = 12;
    localparam logic [3:0] WD_OFF = 4'h0;
    localparam logic [3:0] WD_DIRECT = 4'hF;
    localparam int WD_UNIT_US = 1000;
    localparam int WD_UNIT_CYC = WD_UNIT_US * CLK_MHZ;
    localparam logic [7:0] THR_RESET = 8'h00;
    localparam logic [7:0] THR_MIN = 8'h3E;
    localparam logic [7:0] THR_SPAN = 8'hBA;
    localparam int OPEN_DEG_US = 10;
    localparam int SHORT_DEG_US = 10;
    localparam int OPEN_DEG_CYC = OPEN_DEG_US * CLK_MHZ;
    localparam int SHORT_DEG_CYC = SHORT_DEG_US * CLK_MHZ;
    localparam int ODPW_UNIT_CYC = CLK_MHZ;

    typedef struct packed {
        logic low_supply;
        logic reference;
        logic thermal_warning;
        logic overtemp;
        logic output_fault;
        logic global_fault;
    } lfm_flags_s;

    typedef enum logic [1:0] {
        ST_NORMAL = 2'b00,
        ST_FAILSAFE0 = 2'b01,
        ST_FAILSAFE1 = 2'b10
    } lfm_state_e;
endpackage

/* verilog/lfm_chan_diag.sv */
// Purpose: per-channel open and short deglitch on PWM on-time
// Assumes: comparator inputs already synchronised
// Notes: raises a one-cycle event when a fault outlasts its window
`timescale 1ns/1ps
module lfm_chan_diag
    import lfm_pkg::*;
#(
    parameter int CW = 24
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic nrst_i,
    // Status
    input wire logic pwm_on_i,
    input wire logic cmp_i,
    input wire logic enable_i,
    input wire logic [CW-1:0] window_i,
    // Event
    output logic event_o
);
    logic [CW-1:0] cnt_q, cnt_d;
    logic done_q, done_d;
    logic event_q, event_d;

    // =====================================
    // Deglitch
    always_comb begin
        cnt_d = '0;
        done_d = 1'b0;
        event_d = 1'b0;
        if (pwm_on_i && cmp_i && enable_i) begin
            done_d = done_q;
            cnt_d = cnt_q;
            if (cnt_q < window_i) begin
                cnt_d = cnt_q + 1'b1;
            end else if (!done_q) begin
                // One event per unbroken fault within an on-time pulse avoids flooding the fault pin
                event_d = 1'b1;
                done_d = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            cnt_q <= '0;
            done_q <= 1'b0;
            event_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            done_q <= done_d;
            event_q <= event_d;
        end
    end
    assign event_o = event_q;

    property p_win;
        @(posedge mclk_i) disable iff (!nrst_i) event_q |-> $past(pwm_on_i) && $past(cmp_i);
    endproperty
    a_win: assert property (p_win) else $error("event outside on-time");
endmodule

/* bench/lfm_host_model.sv */
// Purpose: master controller model, clear writes and frame reports
// Assumes: one-cycle requests launched just after a rising edge
// Notes: frame contents reduced to the receiver's qualifiers
`timescale 1ns/1ps
module lfm_host_model (
    // Clock
    input wire logic mclk_i,
    // Requests
    output logic clear_faults_o,
    output logic frame_ok_o,
    output logic frame_broadcast_o,
    output logic frame_addr_match_o
);
    initial begin
        clear_faults_o = 1'h0;
        {frame_ok_o, frame_broadcast_o, frame_addr_match_o} = 3'h0;
    end
    // ========================================
    // Requests
    // One-cycle clear write
    task automatic clear_flags();
        @(posedge mclk_i);
        clear_faults_o <= 1'h1;
        @(posedge mclk_i);
        clear_faults_o <= 1'h0;
    endtask
    task automatic send_frame(input logic ok, input logic bc, input logic am);
        @(posedge mclk_i);
        {frame_ok_o, frame_broadcast_o, frame_addr_match_o} <= {ok, bc, am};
        @(posedge mclk_i);
        {frame_ok_o, frame_broadcast_o, frame_addr_match_o} <= 3'h0;
    endtask
endmodule

/* bench/lfm_top_tb.sv */
// Purpose: self-checking bench for the fault monitor
// Assumes: short counts set by parameters below
// Notes: fault pin modelled with a pull-up
`timescale 1ns/1ps
module lfm_top_tb;
    import lfm_pkg::*;
    logic mclk_i, nrst_i, adc_done_i, idle, ref_open_i, ref_short_i, warn, hot, fs_sel;
    logic [7:0] adc_code_i, thr_code, sup_res, sup_thr;
    logic [NCH-1:0] pwm_on_i, open_cmp_i, short_cmp_i, ch_open, ch_short;
    logic [3:0] odpw, wd_per, wd_stored;
    logic clr, f_ok, f_bc, f_am, clr_back, out_en, diag_en, fault_n, fault_oe;
    logic msk_open, msk_short;
    lfm_flags_s flags;
    lfm_state_e state;
    int err_total, checks;
    // Released pin floats to the pull-up
    wire err_pin_n = fault_oe ? 1'h0 : 1'h1;

    lfm_top #(.PULSE_CYCLES(20), .WD_UNIT_CYCLES(50), .DEG_OPEN_CYCLES(4),
        .DEG_SHORT_CYCLES(4), .ODPW_CYCLES(2)) lfm_top_inst (
        .mclk_i(mclk_i), .nrst_i(nrst_i), .adc_done_i(adc_done_i), .adc_idle_i(idle),
        .adc_code_i(adc_code_i), .low_supply_threshold_i(thr_code),
        .ref_open_i(ref_open_i), .ref_short_i(ref_short_i), .thermal_warn_i(warn),
        .overtemp_i(hot), .pwm_on_i(pwm_on_i), .open_cmp_i(open_cmp_i),
        .short_cmp_i(short_cmp_i), .diag_pulse_width_i(odpw),
        .watchdog_period_i(wd_per), .stored_watchdog_period_i(wd_stored),
        .failsafe_select_i(fs_sel), .mask_open_i(msk_open), .mask_short_i(msk_short),
        .clear_faults_i(clr), .frame_ok_i(f_ok), .frame_broadcast_i(f_bc),
        .frame_addr_match_i(f_am), .supply_result_o(sup_res),
        .supply_threshold_o(sup_thr), .flags_o(flags), .channel_open_flag_o(ch_open),
        .channel_short_flag_o(ch_short), .clear_faults_o(clr_back),
        .outputs_enable_o(out_en), .diag_enable_o(diag_en), .state_o(state),
        .fault_n_o(fault_n), .fault_oe_o(fault_oe));

    lfm_host_model lfm_host_model_inst (.mclk_i(mclk_i), .clear_faults_o(clr),
        .frame_ok_o(f_ok), .frame_broadcast_o(f_bc), .frame_addr_match_o(f_am));

    // ========================================
    // Helpers
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    task automatic do_reset();
        @(posedge mclk_i);
        nrst_i <= 1'h0;
        repeat (3) @(posedge mclk_i);
        nrst_i <= 1'h1;
        cyc(1);
    endtask
    task automatic adc_conv(input logic [7:0] code);
        @(posedge mclk_i);
        adc_code_i <= code;
        adc_done_i <= 1'h1;
        @(posedge mclk_i);
        adc_done_i <= 1'h0;
        #1;
    endtask
    task automatic chan_fault(input logic sh, input int ch, input int len);
        @(posedge mclk_i);
        pwm_on_i[ch] <= 1'h1;
        short_cmp_i[ch] <= sh;
        open_cmp_i[ch] <= ~sh;
        repeat (len) @(posedge mclk_i);
        pwm_on_i <= 12'h000;
        short_cmp_i <= 12'h000;
        open_cmp_i <= 12'h000;
        cyc(1);
    endtask
    task automatic chk_pulse();
        chk("pin low", {fault_n, err_pin_n}, 2'h0);
        cyc(10);
        chk("pulse held", {fault_n, err_pin_n}, 2'h0);
        cyc(14);
        chk("pulse end", {fault_n, err_pin_n}, 2'h3);
    endtask
    task automatic clear_all();
        lfm_host_model_inst.clear_flags();
        #1;
        chk("clear bit", clr_back, 1'h1);
        cyc(1);
        chk("clear back", clr_back, 1'h0);
        chk("flags clr", {flags, ch_open, ch_short}, 30'h0);
    endtask
    task automatic wrap_up();
        if (err_total == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ========================================
    // Stimulus
    initial begin
        mclk_i = 1'h0;
        forever #2.5 mclk_i = ~mclk_i;
    end
    initial begin
        repeat (20000) @(posedge mclk_i);
        err_total++;
        wrap_up();
    end
    initial begin
        {nrst_i, adc_done_i, ref_open_i, ref_short_i, warn, hot, fs_sel} = 7'h00;
        {msk_open, msk_short} = 2'h0;
        {adc_code_i, thr_code, wd_per, wd_stored} = 24'h0;
        {pwm_on_i, open_cmp_i, short_cmp_i} = 36'h0;
        idle = 1'h1;
        odpw = 4'h1;
        err_total = 0;
        checks = 0;
        do_reset();
        chk("reset outs", {flags, err_pin_n, out_en, diag_en}, 9'h007);
        chk("reset state", state, ST_NORMAL);
        chk("thr min", sup_thr, 8'h3E);
        @(posedge mclk_i);
        thr_code <= 8'hFF;
        cyc(3);
        chk("thr max", sup_thr, 8'hF7);
        thr_code <= 8'h80;
        cyc(3);
        chk("thr mid", sup_thr, 8'h9B);
        adc_conv(8'h20);
        chk("result", sup_res, 8'h20);
        cyc(3);
        chk_pulse();
        chk("low flag", flags.low_supply, 1'h1);
        chk("diag off", diag_en, 1'h0);
        chan_fault(1'h0, 0, 20);
        cyc(3);
        chk("open when low", {ch_open, err_pin_n}, 13'h0001);
        adc_conv(8'hF0);
        chk("result", sup_res, 8'hF0);
        cyc(3);
        chk("diag on", diag_en, 1'h1);
        idle <= 1'h0;
        adc_conv(8'h10);
        chk("busy adc", {sup_res, diag_en}, 9'h1E1);
        idle <= 1'h1;
        clear_all();
        chan_fault(1'h0, 5, 5);
        cyc(10);
        chk("short on open", ch_open, 12'h000);
        odpw <= 4'h2;
        chan_fault(1'h0, 5, 10);
        cyc(10);
        chk("wider window", ch_open, 12'h000);
        odpw <= 4'h1;
        chan_fault(1'h0, 3, 16);
        chk_pulse();
        chk("open flags", {ch_open, flags}, {12'h008, 6'h03});
        clear_all();
        chan_fault(1'h1, 9, 5);
        cyc(10);
        chk("short on short", ch_short, 12'h000);
        chan_fault(1'h1, 7, 16);
        chk_pulse();
        cyc(20);
        chk("short flags", {ch_short, flags}, {12'h080, 6'h03});
        chk("short no act", out_en, 1'h1);
        clear_all();
        msk_open <= 1'h1;
        msk_short <= 1'h1;
        chan_fault(1'h0, 2, 16);
        chan_fault(1'h1, 4, 16);
        cyc(3);
        chk("masked", {ch_open, ch_short, flags, err_pin_n}, 31'h1);
        msk_open <= 1'h0;
        msk_short <= 1'h0;
        for (int i = 0; i < 2; i++) begin
            @(posedge mclk_i);
            {ref_open_i, ref_short_i} <= i ? 2'h1 : 2'h2;
            cyc(30);
            chk("ref held", {err_pin_n, flags.reference, flags.global_fault}, 3'h3);
            chk("ref no act", out_en, 1'h1);
            {ref_open_i, ref_short_i} <= 2'h0;
            cyc(30);
            chk("ref release", err_pin_n, 1'h1);
            clear_all();
        end
        @(posedge mclk_i);
        hot <= 1'h1;
        cyc(30);
        chk("ot", {out_en, err_pin_n, flags.overtemp, flags.global_fault}, 4'h3);
        hot <= 1'h0;
        cyc(30);
        chk("ot recover", {out_en, err_pin_n}, 2'h3);
        chk("ot sticky", flags.overtemp, 1'h1);
        clear_all();
        @(posedge mclk_i);
        warn <= 1'h1;
        repeat (5) @(posedge mclk_i);
        warn <= 1'h0;
        cyc(3);
        chk_pulse();
        chk("warn flag", flags.thermal_warning, 1'h1);
        do_reset();
        chk("flags after reset", flags, 6'h00);
        @(posedge mclk_i);
        wd_per <= 4'h1;
        fs_sel <= 1'h1;
        for (int i = 0; i < 10; i++) begin
            lfm_host_model_inst.send_frame(1'h1, 1'h0, 1'h1);
            cyc(15);
        end
        chk("wd kicked", state, ST_NORMAL);
        for (int i = 0; i < 12; i++) begin
            lfm_host_model_inst.send_frame(i % 3 != 0, i % 3 == 0, i % 3 != 1);
            cyc(15);
        end
        chk("wd fs1", state, ST_FAILSAFE1);
        fs_sel <= 1'h0;
        do_reset();
        cyc(250);
        chk("wd fs0", state, ST_FAILSAFE0);
        wd_per <= 4'h0;
        do_reset();
        cyc(300);
        chk("wd off", state, ST_NORMAL);
        wd_stored <= 4'hF;
        do_reset();
        cyc(10);
        chk("wd direct", state, ST_FAILSAFE0);
        wrap_up();
    end
endmodule
